/* logic/txsp_params.svh */
// Offsets, field positions and reset values of the sample port
`ifndef TXSP_PARAMS_SVH
`define TXSP_PARAMS_SVH
`define TXSP_W         12
`define TXSP_AW        8
`define TXSP_CTRL_ADDR 8'h00
`define TXSP_STAT_ADDR 8'h04
`define TXSP_DIV_ADDR  8'h08
`define TXSP_DAC_ADDR  8'h0c
`define TXSP_CTRL_RST  32'h0000_0000
`define TXSP_DIV_RST   16'h0010
`define TXSP_B_HALF    0
`define TXSP_B_DDR     1
`define TXSP_B_ORDER   2
`define TXSP_B_POL     3
`define TXSP_B_FMT     4
`define TXSP_B_DRIVE   5
`define TXSP_B_TWOCLK  6
`define TXSP_B_PINDIR  7
`define TXSP_B_TXON    8
`define TXSP_B_RXON    9
`define TXSP_B_RXINV   10
`define TXSP_B_RXORDER 11
`define TXSP_B_RXPOL   12
`define TXSP_OKAY      2'h0
`define TXSP_SLVERR    2'h2
`endif

/* logic/txsp_pkg.sv */
// Types of the sample port
package txsp_pkg;
   typedef enum logic [1:0] {DIR_HIZ, DIR_RX, DIR_TX} txsp_dir_t;
endpackage

/* logic/txsp_port.sv */
// Transmit and half-duplex sample port with AXI4-Lite control
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "txsp_params.svh"
// Function
// - Single-edge: capture word and tag on rise
// - Pair consecutive words, order bit selects
// - Polarity bit selects which tag means I
// - Format bit: unsigned or twos complement
// - DDR: capture on both clock edges
// - DDR: edge picks channel, tag ignored
// - Single-edge: clock input or driven out
// - Half-duplex shares bus, direction pin/bits
// - Half-duplex transmit: words from shared pins
// - One-clock: shared clock follows direction
// - Two-clock: shared rx, dedicated tx
// - Driven clocks toggle only when direction active
// - Receive direction sources as full-duplex
// - Enable bits: off hiz, rx, tx, both rx
// - Pin low receive, high transmit
// - Dedicated bus undriven in half-duplex
// - Full-duplex independent, half disables dedicated bus and tag
// - Receive driven on clock rise, invert option
module txsp_port (
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite slave
   input  wire logic [`TXSP_AW-1:0]  s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [`TXSP_AW-1:0]  s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Dedicated transmit pins
   input  wire logic [`TXSP_W-1:0]   tx_sample_bus,
   input  wire logic                 transmit_channel_tag,
   input  wire logic                 transmit_qualifier_clock_i,
   output logic                      transmit_qualifier_clock_o,
   output logic                      transmit_qualifier_clock_oe,
   // Shared port pins
   input  wire logic [`TXSP_W-1:0]   shared_sample_bus_i,
   output logic [`TXSP_W-1:0]        shared_sample_bus_o,
   output logic                      shared_sample_bus_oe,
   input  wire logic                 shared_channel_tag_i,
   output logic                      shared_channel_tag_o,
   output logic                      shared_channel_tag_oe,
   input  wire logic                 shared_port_clock_i,
   output logic                      shared_port_clock_o,
   output logic                      shared_port_clock_oe,
   input  wire logic                 direction_select_pin,
   // Receive samples from the converter core
   input  wire logic [`TXSP_W-1:0]   rx_i_sample,
   input  wire logic [`TXSP_W-1:0]   rx_q_sample,
   input  wire logic                 rx_sample_valid,
   output logic                      rx_sample_ready,
   // Quadrature pairs to the DACs, twos complement
   output logic [`TXSP_W-1:0]        dac_i_word,
   output logic [`TXSP_W-1:0]        dac_q_word,
   output logic                      dac_pair_valid
);
   localparam int SW = 2 * `TXSP_W + 5;

   function automatic txsp_pkg::txsp_dir_t dir_decode(
      input logic half, input logic pindir, input logic pin,
      input logic txon, input logic rxon);
      txsp_pkg::txsp_dir_t d;
      d = txsp_pkg::DIR_RX;
      if (half && pindir) begin
         d = pin ? txsp_pkg::DIR_TX : txsp_pkg::DIR_RX;
      end else if (half) begin
         if (rxon) d = txsp_pkg::DIR_RX;
         else if (txon) d = txsp_pkg::DIR_TX;
         else d = txsp_pkg::DIR_HIZ;
      end
      return d;
   endfunction

   function automatic logic [`TXSP_W-1:0] to_twos(
      input logic [`TXSP_W-1:0] w, input logic twos);
      return twos ? w : {~w[`TXSP_W-1], w[`TXSP_W-2:0]};
   endfunction

   function automatic logic [31:0] merge(
      input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   logic [31:0]          ctrl_r;
   logic [15:0]          div_r;
   logic [15:0]          div_cnt_r;
   logic                 gen_clk_r;
   logic [SW-1:0]        sync1_r;
   logic [SW-1:0]        sync2_r;
   logic                 tx_clk_prev_r;
   logic                 aw_have_r;
   logic                 w_have_r;
   logic [`TXSP_AW-1:0]  aw_addr_r;
   logic [31:0]          w_data_r;
   logic [3:0]           w_strb_r;
   logic [`TXSP_W-1:0]   first_r;
   logic                 have_r;
   logic [15:0]          pair_cnt_r;
   logic [`TXSP_W-1:0]   rxi_r;
   logic [`TXSP_W-1:0]   rxq_r;
   logic                 rx_full_r;
   logic                 rx_phase_r;
   txsp_pkg::txsp_dir_t  dir;

   // Synchronised pin levels
   logic [`TXSP_W-1:0]   ded_data_s;
   logic [`TXSP_W-1:0]   sh_data_s;
   logic                 ded_tag_s;
   logic                 ded_clk_s;
   logic                 sh_tag_s;
   logic                 sh_clk_s;
   logic                 dir_pin_s;
   assign {ded_data_s, sh_data_s, ded_tag_s, ded_clk_s, sh_tag_s, sh_clk_s, dir_pin_s}
      = sync2_r;

   logic half;
   logic ddr;
   logic two_clk;
   logic own_tx_clk;
   assign half       = ctrl_r[`TXSP_B_HALF];
   assign ddr        = ctrl_r[`TXSP_B_DDR];
   assign two_clk    = ctrl_r[`TXSP_B_TWOCLK];
   assign own_tx_clk = ctrl_r[`TXSP_B_DRIVE] && !ddr;
   assign dir = dir_decode(half, ctrl_r[`TXSP_B_PINDIR], dir_pin_s,
                           ctrl_r[`TXSP_B_TXON], ctrl_r[`TXSP_B_RXON]);

   // Local clock for everything the device drives
   logic gen_tick;
   logic gen_rise;
   logic gen_fall;
   assign gen_tick = (div_cnt_r + 16'h0001 >= div_r);
   assign gen_rise = gen_tick && !gen_clk_r;
   assign gen_fall = gen_tick && gen_clk_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_r <= 16'h0000;
         gen_clk_r <= 1'b0;
      end else if (gen_tick) begin
         div_cnt_r <= 16'h0000;
         gen_clk_r <= !gen_clk_r;
      end else begin
         div_cnt_r <= div_cnt_r + 16'h0001;
      end
   end

   // Two stages on every pin input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {tx_sample_bus, shared_sample_bus_i, transmit_channel_tag,
                     transmit_qualifier_clock_i, shared_channel_tag_i,
                     shared_port_clock_i, direction_select_pin};
         sync2_r <= sync1_r;
      end
   end

   // Transmit source selection
   logic                use_shared;
   logic                cap_en;
   logic                tx_clk_in;
   logic [`TXSP_W-1:0]  tx_word;
   logic                tx_tag;
   assign use_shared = half && (dir == txsp_pkg::DIR_TX);
   assign cap_en     = !half || use_shared;
   assign tx_clk_in  = (half && !two_clk) ? sh_clk_s : ded_clk_s;
   assign tx_word    = use_shared ? sh_data_s : ded_data_s;
   assign tx_tag     = use_shared ? sh_tag_s : ded_tag_s;

   logic tx_rise;
   logic tx_fall;
   assign tx_rise = own_tx_clk ? gen_rise : (tx_clk_in && !tx_clk_prev_r);
   assign tx_fall = own_tx_clk ? gen_fall : (!tx_clk_in && tx_clk_prev_r);

   logic edge_hit;
   logic tag_eff;
   logic is_i;
   logic is_first;
   assign edge_hit = tx_rise || (ddr && tx_fall);
   assign tag_eff  = ddr ? tx_rise : tx_tag;
   assign is_i     = (tag_eff == ctrl_r[`TXSP_B_POL]);
   assign is_first = (is_i == ctrl_r[`TXSP_B_ORDER]);

   always_ff @(posedge aclk) begin
      if (!aresetn) tx_clk_prev_r <= 1'b0;
      else tx_clk_prev_r <= tx_clk_in;
   end

   // Pair assembly; a lone second word is dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_r        <= '0;
         have_r         <= 1'b0;
         dac_i_word     <= '0;
         dac_q_word     <= '0;
         dac_pair_valid <= 1'b0;
         pair_cnt_r     <= 16'h0000;
      end else begin
         dac_pair_valid <= 1'b0;
         if (!cap_en) begin
            have_r <= 1'b0;
         end else if (edge_hit && is_first) begin
            first_r <= tx_word;
            have_r  <= 1'b1;
         end else if (edge_hit && have_r) begin
            have_r         <= 1'b0;
            dac_pair_valid <= 1'b1;
            pair_cnt_r     <= pair_cnt_r + 16'h0001;
            dac_i_word <= to_twos(is_i ? tx_word : first_r, ctrl_r[`TXSP_B_FMT]);
            dac_q_word <= to_twos(is_i ? first_r : tx_word, ctrl_r[`TXSP_B_FMT]);
         end
      end
   end

   // Receive words onto the shared port
   logic rx_dir;
   logic rx_take;
   logic rx_done;
   assign rx_dir  = (dir == txsp_pkg::DIR_RX);
   assign rx_take = rx_sample_valid && rx_sample_ready;
   assign rx_done = rx_dir && gen_rise && rx_full_r && rx_phase_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxi_r                <= '0;
         rxq_r                <= '0;
         rx_full_r            <= 1'b0;
         rx_phase_r           <= 1'b0;
         rx_sample_ready      <= 1'b0;
         shared_sample_bus_o  <= '0;
         shared_channel_tag_o <= 1'b0;
      end else begin
         rx_sample_ready <= !(rx_full_r && !rx_done) && !rx_take;
         if (rx_take) begin
            rxi_r     <= rx_i_sample;
            rxq_r     <= rx_q_sample;
            rx_full_r <= 1'b1;
         end else if (rx_done) begin
            rx_full_r <= 1'b0;
         end
         // Launch on local rise; inversion only flips the pin
         if (rx_dir && gen_rise && rx_full_r) begin
            rx_phase_r <= !rx_phase_r;
            if (rx_phase_r == ctrl_r[`TXSP_B_RXORDER]) begin
               shared_sample_bus_o  <= rxq_r;
               shared_channel_tag_o <= !ctrl_r[`TXSP_B_RXPOL];
            end else begin
               shared_sample_bus_o  <= rxi_r;
               shared_channel_tag_o <= ctrl_r[`TXSP_B_RXPOL];
            end
         end
      end
   end

   // Pin drivers; the dedicated data bus is never driven
   logic rx_clk_lvl;
   assign rx_clk_lvl = (gen_clk_r ^ gen_tick) ^ ctrl_r[`TXSP_B_RXINV];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shared_sample_bus_oe        <= 1'b0;
         shared_channel_tag_oe       <= 1'b0;
         shared_port_clock_oe        <= 1'b0;
         shared_port_clock_o         <= 1'b0;
         transmit_qualifier_clock_oe <= 1'b0;
         transmit_qualifier_clock_o  <= 1'b0;
      end else begin
         shared_sample_bus_oe  <= rx_dir;
         shared_channel_tag_oe <= rx_dir;
         transmit_qualifier_clock_oe <= own_tx_clk && (!half || two_clk);
         transmit_qualifier_clock_o  <= gen_clk_r && own_tx_clk
                                        && (!half || use_shared);
         if (!half || two_clk) begin
            shared_port_clock_oe <= 1'b1;
            shared_port_clock_o  <= rx_dir && rx_clk_lvl;
         end else if (rx_dir) begin
            shared_port_clock_oe <= 1'b1;
            shared_port_clock_o  <= rx_clk_lvl;
         end else begin
            shared_port_clock_oe <= use_shared && own_tx_clk;
            shared_port_clock_o  <= use_shared && own_tx_clk && gen_clk_r;
         end
      end
   end

   // AXI4-Lite write path
   logic wr_fire;
   logic wr_ok;
   assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wr_ok   = (aw_addr_r == `TXSP_CTRL_ADDR) || (aw_addr_r == `TXSP_DIV_ADDR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= '0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TXSP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `TXSP_OKAY : `TXSP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // A divider write of zero is held at one; zero would also toggle the local clock every cycle
   logic [31:0] div_mg;
   assign div_mg = merge({16'h0000, div_r}, w_data_r, w_strb_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `TXSP_CTRL_RST;
         div_r  <= `TXSP_DIV_RST;
      end else if (wr_fire && aw_addr_r == `TXSP_CTRL_ADDR) begin
         ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_1fff;
      end else if (wr_fire && aw_addr_r == `TXSP_DIV_ADDR) begin
         div_r <= (div_mg[15:0] == 16'h0000) ? 16'h0001 : div_mg[15:0];
      end
   end

   // AXI4-Lite read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `TXSP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `TXSP_OKAY;
         case (s_axi_araddr)
            `TXSP_CTRL_ADDR: s_axi_rdata <= ctrl_r;
            `TXSP_STAT_ADDR: s_axi_rdata <= {12'h000, dir, rx_full_r, have_r,
                                             pair_cnt_r};
            `TXSP_DIV_ADDR:  s_axi_rdata <= {16'h0000, div_r};
            `TXSP_DAC_ADDR:  s_axi_rdata <= {8'h00, dac_q_word, dac_i_word};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `TXSP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // txsp_port
`default_nettype wire

/* testbench/txsp_props.sv */
// Port checker for the sample port
`timescale 1ns/10ps
`default_nettype none
`include "txsp_params.svh"
module txsp_props (
   // Clock and reset
   input wire logic               aclk,
   input wire logic               aresetn,
   // Bus answers
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [1:0]         s_axi_bresp,
   // Shared pins
   input wire logic [`TXSP_W-1:0] shared_sample_bus_o,
   input wire logic               shared_sample_bus_oe,
   input wire logic               shared_channel_tag_o,
   input wire logic               shared_channel_tag_oe,
   input wire logic               shared_port_clock_o,
   input wire logic               shared_port_clock_oe,
   // Pairs
   input wire logic [`TXSP_W-1:0] dac_i_word,
   input wire logic [`TXSP_W-1:0] dac_q_word,
   input wire logic               dac_pair_valid
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
   a_resp_holds: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data moved");
   a_pair_single: assert property (dac_pair_valid |=> !dac_pair_valid)
      else $error("pair strobe too long");
   a_dac_on_pair: assert property ($changed({dac_i_word, dac_q_word}) |-> dac_pair_valid)
      else $error("pair words moved without strobe");
   a_tag_with_bus: assert property (shared_sample_bus_oe == shared_channel_tag_oe)
      else $error("tag and bus enables differ");
   a_rx_clock_on: assert property (shared_sample_bus_oe |-> shared_port_clock_oe)
      else $error("receive data without clock");
   a_data_on_edge: assert property (shared_sample_bus_oe && $past(shared_sample_bus_oe)
      && $changed(shared_sample_bus_o) |-> $changed(shared_port_clock_o))
      else $error("receive data off clock edge");
   a_tag_on_edge: assert property (shared_channel_tag_oe && $past(shared_channel_tag_oe)
      && $changed(shared_channel_tag_o) |-> $changed(shared_port_clock_o))
      else $error("receive tag off clock edge");
endmodule // txsp_props
bind txsp_port txsp_props u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .shared_sample_bus_o, .shared_sample_bus_oe, .shared_channel_tag_o, .shared_channel_tag_oe,
   .shared_port_clock_o, .shared_port_clock_oe, .dac_i_word, .dac_q_word, .dac_pair_valid);
`default_nettype wire

/* testbench/txsp_bbp_model.sv */
// Baseband partner model: transmit words, link clock, direction pin
`timescale 1ns/10ps
`default_nettype none
`include "txsp_params.svh"
module txsp_bbp_model (
   // Clock
   input  wire logic               aclk,
   // Link pins
   output logic                    lclk,
   output logic [`TXSP_W-1:0]      ldata,
   output logic                    ltag,
   output logic                    dir_pin
);
   initial begin
      {lclk, ltag, dir_pin} = 3'h0;
      ldata = 12'h0;
   end
   // Quarter of the 160 ns link period
   task automatic qtr();
      repeat (8) @(posedge aclk);
   endtask
   task automatic send_se(input logic [`TXSP_W-1:0] w, input logic t);
      ldata <= w;
      ltag <= t;
      qtr();
      lclk <= 1'b1;
      qtr();
      qtr();
      lclk <= 1'b0;
      ldata <= ~w;
      ltag <= ~t;
      qtr();
   endtask
   // Tag held wrong on purpose: edge alone names the channel
   task automatic send_ddr(input logic [`TXSP_W-1:0] a, input logic [`TXSP_W-1:0] b);
      ldata <= a;
      ltag <= 1'b0;
      qtr();
      lclk <= 1'b1;
      qtr();
      ldata <= b;
      qtr();
      lclk <= 1'b0;
      qtr();
      ldata <= ~b;
      qtr();
   endtask
   task automatic set_pin(input logic v);
      dir_pin <= v;
   endtask
endmodule // txsp_bbp_model
`default_nettype wire

/* testbench/test_tx_and_half_duplex_sample_port.sv */
// Register-driven test of the sample port
`timescale 1ns/10ps
`default_nettype none
`include "txsp_params.svh"
module test_tx_and_half_duplex_sample_port;
   logic                aclk, aresetn, route_sh, lclk, ltag, direction_select_pin;
   logic [7:0]          s_axi_awaddr, s_axi_araddr;
   logic [31:0]         s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp;
   logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic                s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [`TXSP_W-1:0]  tx_sample_bus, shared_sample_bus_i, shared_sample_bus_o, ldata;
   logic [`TXSP_W-1:0]  rx_i_sample, rx_q_sample, dac_i_word, dac_q_word, cap_i, cap_q;
   logic                transmit_channel_tag, transmit_qualifier_clock_i;
   logic                transmit_qualifier_clock_o, transmit_qualifier_clock_oe;
   logic                shared_sample_bus_oe, shared_channel_tag_i, shared_channel_tag_o;
   logic                shared_channel_tag_oe, shared_port_clock_i, shared_port_clock_o;
   logic                shared_port_clock_oe, rx_sample_valid, rx_sample_ready, dac_pair_valid;
   int                  num_errors = 0, compares = 0, pairs = 0, cyc = 0;
   // Unused path sees inverted data, so a wrong source shows up
   assign tx_sample_bus = route_sh ? ~ldata : ldata;
   assign transmit_channel_tag = route_sh ? ~ltag : ltag;
   assign transmit_qualifier_clock_i = transmit_qualifier_clock_oe ? transmit_qualifier_clock_o
      : (route_sh ? 1'b0 : lclk);
   assign shared_sample_bus_i = shared_sample_bus_oe ? shared_sample_bus_o
      : (route_sh ? ldata : ~ldata);
   assign shared_channel_tag_i = shared_channel_tag_oe ? shared_channel_tag_o
      : (route_sh ? ltag : ~ltag);
   assign shared_port_clock_i = shared_port_clock_oe ? shared_port_clock_o
      : (route_sh ? lclk : 1'b0);
   txsp_port dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tx_sample_bus, .transmit_channel_tag,
      .transmit_qualifier_clock_i, .transmit_qualifier_clock_o, .transmit_qualifier_clock_oe,
      .shared_sample_bus_i, .shared_sample_bus_o, .shared_sample_bus_oe, .shared_channel_tag_i,
      .shared_channel_tag_o, .shared_channel_tag_oe, .shared_port_clock_i, .shared_port_clock_o,
      .shared_port_clock_oe, .direction_select_pin, .rx_i_sample, .rx_q_sample,
      .rx_sample_valid, .rx_sample_ready, .dac_i_word, .dac_q_word, .dac_pair_valid);
   txsp_bbp_model u_bbp (.aclk, .lclk, .ldata, .ltag, .dir_pin(direction_select_pin));
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (dac_pair_valid === 1'b1) begin
         pairs <= pairs + 1;
         cap_i <= dac_i_word;
         cap_q <= dac_q_word;
      end
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         $display("[ERR] %0t run timed out", $time);
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b, bv;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h6;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid && s_axi_bready;
         bv = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (bv && !b) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, rv;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      rv = 1'b0;
      while (!rv) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wbus(input logic [`TXSP_W-1:0] v, input logic t, input logic c);
      int n;
      n = 0;
      while (shared_sample_bus_o !== v && n < 300) begin
         @(negedge aclk);
         n++;
      end
      chk(32'(shared_sample_bus_o), 32'(v));
      chk(32'(shared_channel_tag_o), 32'(t));
      chk(32'(shared_port_clock_o), 32'(c));
   endtask
   task automatic pair_chk(input int p0, input int n, input logic [11:0] ei, input logic [11:0] eq);
      repeat (8) @(posedge aclk);
      chk(32'(pairs - p0), 32'(n));
      if (n > 0) chk({20'h0, cap_i, cap_q}, {20'h0, ei, eq});
   endtask
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      int k;
      logic [1:0] r;
      logic [31:0] d;
      logic ft;
      logic [11:0] wi, wq;
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
      {s_axi_rready, rx_sample_valid, route_sh, s_axi_awaddr, s_axi_araddr} = 19'h0;
      {s_axi_wdata, rx_i_sample, rx_q_sample} = 56'h0;
      s_axi_wstrb = 4'hf;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(8'h00, d, r);
      chk(d, 32'h0);
      axr(8'h08, d, r);
      chk(d, 32'h10);
      axr(8'h10, d, r);
      chk({d[29:0], r}, {30'h0, `TXSP_SLVERR});
      axw(8'h10, 32'h5, r);
      chk(32'(r), 32'(`TXSP_SLVERR));
      $display("test registers done");
      // Four pairing modes, both formats; a lone second word goes first
      for (k = 0; k < 4; k++) begin
         axw(8'h00, {27'h0, k[0], k[0], k[1], 2'h0}, r);
         wi = 12'h8a1 ^ 12'(k);
         wq = 12'h35c ^ 12'(k);
         ft = k[1] ? k[0] : ~k[0];
         d = pairs;
         u_bbp.send_se(k[1] ? wq : wi, ~ft);
         u_bbp.send_se(k[1] ? wi : wq, ft);
         u_bbp.send_se(k[1] ? wq : wi, ~ft);
         pair_chk(d, 1, k[0] ? wi : {~wi[11], wi[10:0]}, k[0] ? wq : {~wq[11], wq[10:0]});
      end
      $display("test single edge done");
      axw(8'h00, 32'h3e, r);
      d = pairs;
      u_bbp.send_ddr(12'h7e1, 12'h0f2);
      pair_chk(d, 1, 12'h7e1, 12'h0f2);
      chk(32'(transmit_qualifier_clock_oe), 32'h0);
      $display("test double edge done");
      route_sh <= 1'b1;
      for (k = 0; k < 4; k++) begin
         axw(8'h00, 32'h1d | (32'(k) << 8), r);
         wi = (k == 0) ? 12'h0 : ((k == 1) ? 12'h2 : 12'h1);
         axr(8'h04, d, r);
         chk(32'(d[19:18]), 32'(wi[1:0]));
         chk(32'(shared_sample_bus_oe), 32'(wi == 12'h1));
         d = pairs;
         u_bbp.send_se(12'h456 ^ 12'(k), 1'b1);
         u_bbp.send_se(12'h9ab, 1'b0);
         pair_chk(d, (k == 1) ? 1 : 0, 12'h457, 12'h9ab);
      end
      axw(8'h00, 32'h9d, r);
      for (k = 0; k < 2; k++) begin
         u_bbp.set_pin(k[0]);
         repeat (4) @(posedge aclk);
         axr(8'h04, d, r);
         chk(32'(d[19:18]), k ? 32'h2 : 32'h1);
      end
      $display("test half duplex done");
      route_sh <= 1'b0;
      for (k = 0; k < 2; k++) begin
         axw(8'h00, 32'h1800 | (32'(k) << 10), r);
         wi = 12'habc ^ {12{k[0]}};
         wq = 12'h345 ^ {12{k[0]}};
         rx_i_sample <= wi;
         rx_q_sample <= wq;
         rx_sample_valid <= 1'b1;
         do begin
            @(negedge aclk);
            ft = rx_sample_ready;
            @(posedge aclk);
         end while (ft !== 1'b1);
         rx_sample_valid <= 1'b0;
         wbus(wi, 1'b1, ~k[0]);
         wbus(wq, 1'b0, ~k[0]);
      end
      $display("test receive done");
      tally_and_finish();
   end
endmodule // test_tx_and_half_duplex_sample_port
`default_nettype wire
